// [design/dual_timer.v]
/*
  Two counter/timers with control, mode and clock-select registers on the
  special-function register bus, plus external interrupt flags.
  Assumes all pin inputs are synchronous to core_clk_i and that the CPU
  core issues one byte or one single-bit write per cycle.
*/
`timescale 1ns/100ps
`include "timer_pair_defs.vh"
module dual_timer (
  input  wire       core_clk_i,          // system clock, 10 MHz
  input  wire       rst_i,               // async reset, active high
  input  wire [7:0] sfr_addr_i,          // register address
  input  wire       sfr_wr_i,            // byte write strobe
  input  wire [7:0] sfr_wdata_i,         // byte write data
  input  wire       sfr_bit_wr_i,        // single-bit write strobe
  input  wire [2:0] sfr_bit_sel_i,       // bit index in control register
  input  wire       sfr_bit_val_i,       // value for single-bit write
  output reg  [7:0] sfr_rdata_o,         // read data for sfr_addr_i
  output wire       sfr_hit_o,           // address belongs to this block
  input  wire       count_pin_zero_i,    // timer 0 event pin
  input  wire       count_pin_one_i,     // timer 1 event pin
  input  wire       gating_input_zero_i, // timer 0 gate / ext irq 0 input
  input  wire       gating_input_one_i,  // timer 1 gate / ext irq 1 input
  input  wire       gating_polarity_zero_i, // 1: input 0 active high
  input  wire       gating_polarity_one_i,  // 1: input 1 active high
  input  wire       ext_clk_i,           // external clock for prescaler
  input  wire       vector_t0_i,         // CPU vectors to timer 0 isr
  input  wire       vector_t1_i,         // CPU vectors to timer 1 isr
  input  wire       vector_x0_i,         // CPU vectors to ext irq 0 isr
  input  wire       vector_x1_i,         // CPU vectors to ext irq 1 isr
  output wire       ovf_flag_zero_o,     // timer 0 overflow flag
  output wire       ovf_flag_one_o,      // timer 1 overflow flag
  output wire       ext_irq_flag_zero_o, // ext irq 0 flag
  output wire       ext_irq_flag_one_o,  // ext irq 1 flag
  output reg        t1_ovf_pulse_o       // timer 1 overflow, baud/ADC
);
  reg  [7:0] timer_run_and_flag_control;
  reg  [7:0] timer_mode_select;
  reg  [7:0] timer_clock_select_reg;
  reg  [7:0] low_count_zero;
  reg  [7:0] high_count_zero;
  reg  [7:0] low_count_one;
  reg  [7:0] high_count_one;
  reg  [7:0] next_ctrl;
  reg  [7:0] next_low0;
  reg  [7:0] next_high0;
  reg  [7:0] next_low1;
  reg  [7:0] next_high1;
  reg        next_t1_pulse;
  reg        pin0_prev;
  reg        pin1_prev;
  reg        gin0_prev;
  reg        gin1_prev;
  wire       pre_tick;

  wire       ovf_flag_one      = timer_run_and_flag_control[7];
  wire       run_bit_one       = timer_run_and_flag_control[6];
  wire       ovf_flag_zero     = timer_run_and_flag_control[5];
  wire       run_bit_zero      = timer_run_and_flag_control[4];
  wire       ext_irq_type_one  = timer_run_and_flag_control[2];
  wire       ext_irq_type_zero = timer_run_and_flag_control[0];
  wire       gating_enable_one  = timer_mode_select[7];
  wire       count_select_one   = timer_mode_select[6];
  wire [1:0] mode_field_one     = timer_mode_select[5:4];
  wire       gating_enable_zero = timer_mode_select[3];
  wire       count_select_zero  = timer_mode_select[2];
  wire [1:0] mode_field_zero    = timer_mode_select[1:0];
  wire       sysclk_sel_one     = timer_clock_select_reg[3];
  wire       sysclk_sel_zero    = timer_clock_select_reg[2];
  wire [1:0] prescale_select    = timer_clock_select_reg[1:0];

  // active level of the gating inputs as set by the polarity pins
  wire gin0_act = ~(gating_input_zero_i ^ gating_polarity_zero_i);
  wire gin1_act = ~(gating_input_one_i ^ gating_polarity_one_i);
  wire split    = (mode_field_zero == `MODE_SPLIT);

  // falling edges are seen on a one-cycle delayed copy; the far side
  // holds each level two clocks so no edge is missed
  wire fall0 = pin0_prev & ~count_pin_zero_i;
  wire fall1 = pin1_prev & ~count_pin_one_i;

  // clock source choice shared by both timers and the split high byte
  function tick_src;
    input cnt_sel;
    input sys_sel;
    input pin_fall;
    input pre;
    begin
      if (cnt_sel)
        tick_src = pin_fall;
      else if (sys_sel)
        tick_src = 1'b1;
      else
        tick_src = pre;
    end
  endfunction

  wire gating_enable_zero_ok = ~gating_enable_zero | gin0_act;
  wire gating_enable_one_ok = ~gating_enable_one | gin1_act;
  wire en0 = run_bit_zero & gating_enable_zero_ok &
             tick_src(count_select_zero, sysclk_sel_zero, fall0, pre_tick);
  // split high byte is a timer only: never the pin
  wire en0h = run_bit_one &
              tick_src(1'b0, sysclk_sel_zero, 1'b0, pre_tick);
  // in split mode timer 1 ignores its run bit and gate, runs unless mode 3
  wire en1_split = (mode_field_one != `MODE_SPLIT) &
                   tick_src(1'b0, sysclk_sel_one, 1'b0, pre_tick);
  wire en1_norm  = run_bit_one & gating_enable_one_ok & (mode_field_one != `MODE_SPLIT) &
                   tick_src(count_select_one, sysclk_sel_one, fall1,
                            pre_tick);
  wire en1 = split ? en1_split : en1_norm;

  // single-bit writes address the control register only
  wire bit_wr_ctrl = sfr_bit_wr_i & (sfr_addr_i == `ADDR_CTRL);
  wire wr_ctrl  = sfr_wr_i & (sfr_addr_i == `ADDR_CTRL);
  wire wr_low0  = sfr_wr_i & (sfr_addr_i == `ADDR_LOW_ZERO);
  wire wr_high0 = sfr_wr_i & (sfr_addr_i == `ADDR_HIGH_ZERO);
  wire wr_low1  = sfr_wr_i & (sfr_addr_i == `ADDR_LOW_ONE);
  wire wr_high1 = sfr_wr_i & (sfr_addr_i == `ADDR_HIGH_ONE);

  assign sfr_hit_o = (sfr_addr_i >= `ADDR_CTRL) &
                     (sfr_addr_i <= `ADDR_CLKSEL);

  prescale_gen u_prescale (
    .core_clk_i     (core_clk_i),
    .rst_i          (rst_i),
    .prescale_sel_i (prescale_select),
    .ext_clk_i      (ext_clk_i),
    .tick_o         (pre_tick)
  );

  // one timer's count step; returns {overflow, high, low}
  function [16:0] step_timer;
    input [1:0] mode;
    input [7:0] lo;
    input [7:0] hi;
    reg   [12:0] c13;
    reg   [16:0] c16;
    begin
      c13 = 13'h0000;
      c16 = 17'h00000;
      case (mode)
        `MODE_13: begin
          // upper low bits are left alone and carry no meaning
          c13 = {hi, lo[4:0]} + 13'h0001;
          step_timer = {({hi, lo[4:0]} == 13'h1FFF), c13[12:5],
                        lo[7:5], c13[4:0]};
        end
        `MODE_16: begin
          c16 = {1'b0, hi, lo} + 17'h00001;
          step_timer = c16;
        end
        default: begin
          // reload and split low byte: 8-bit with optional reload
          if (lo == 8'hFF)
            step_timer = {1'b1, hi,
                          (mode == `MODE_RELOAD) ? hi : 8'h00};
          else
            step_timer = {1'b0, hi, lo + 8'h01};
        end
      endcase
    end
  endfunction

  reg [16:0] s0;
  reg [16:0] s1;
  reg        ovf0;
  reg        ovf0h;
  reg        ovf1;
  reg        set_x0;
  reg        set_x1;

  always @* begin
    next_ctrl     = timer_run_and_flag_control;
    next_low0     = low_count_zero;
    next_high0    = high_count_zero;
    next_low1     = low_count_one;
    next_high1    = high_count_one;
    next_t1_pulse = 1'b0;
    ovf0  = 1'b0;
    ovf0h = 1'b0;
    ovf1  = 1'b0;
    s0 = step_timer(mode_field_zero, low_count_zero, high_count_zero);
    s1 = step_timer(mode_field_one, low_count_one, high_count_one);
    // counts move on from their held value; run bit never preloads
    if (en0) begin
      next_low0 = s0[7:0];
      ovf0      = s0[16];
      if (!split)
        next_high0 = s0[15:8];
    end
    if (split && en0h) begin
      next_high0 = high_count_zero + 8'h01;
      ovf0h      = (high_count_zero == 8'hFF);
    end
    if (en1) begin
      next_low1     = s1[7:0];
      next_high1    = s1[15:8];
      ovf1          = s1[16];
      next_t1_pulse = s1[16];
    end
    // cpu byte writes beat the same-cycle count step
    if (wr_low0)  next_low0  = sfr_wdata_i;
    if (wr_high0) next_high0 = sfr_wdata_i;
    if (wr_low1)  next_low1  = sfr_wdata_i;
    if (wr_high1) next_high1 = sfr_wdata_i;

    // software writes and vectoring clears first, hardware sets win after
    if (wr_ctrl)
      next_ctrl = sfr_wdata_i;
    if (bit_wr_ctrl)
      next_ctrl[sfr_bit_sel_i] = sfr_bit_val_i;
    if (vector_t0_i) next_ctrl[`BIT_OVF_ZERO] = 1'b0;
    if (vector_t1_i) next_ctrl[`BIT_OVF_ONE]  = 1'b0;
    if (vector_x0_i && ext_irq_type_zero)
      next_ctrl[`BIT_EXT_ZERO] = 1'b0;
    if (vector_x1_i && ext_irq_type_one)
      next_ctrl[`BIT_EXT_ONE] = 1'b0;

    // type 1: edge into active level; type 0: flag follows the level
    set_x0 = ext_irq_type_zero ? (gin0_act & ~gin0_prev) : gin0_act;
    set_x1 = ext_irq_type_one  ? (gin1_act & ~gin1_prev) : gin1_act;
    if (set_x0) next_ctrl[`BIT_EXT_ZERO] = 1'b1;
    if (set_x1) next_ctrl[`BIT_EXT_ONE]  = 1'b1;
    if (!ext_irq_type_zero && !gin0_act)
      next_ctrl[`BIT_EXT_ZERO] = 1'b0;
    if (!ext_irq_type_one && !gin1_act)
      next_ctrl[`BIT_EXT_ONE] = 1'b0;

    if (ovf0) next_ctrl[`BIT_OVF_ZERO] = 1'b1;
    // in split mode only the high byte of timer 0 may raise flag one
    if (split ? ovf0h : ovf1)
      next_ctrl[`BIT_OVF_ONE] = 1'b1;
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_run_and_flag_control <= `RESET_BYTE;
      timer_mode_select          <= `RESET_BYTE;
      timer_clock_select_reg     <= `RESET_BYTE;
      low_count_zero             <= `RESET_BYTE;
      high_count_zero            <= `RESET_BYTE;
      low_count_one              <= `RESET_BYTE;
      high_count_one             <= `RESET_BYTE;
      t1_ovf_pulse_o             <= 1'b0;
      pin0_prev                  <= 1'b0;
      pin1_prev                  <= 1'b0;
      gin0_prev                  <= 1'b0;
      gin1_prev                  <= 1'b0;
    end else begin
      timer_run_and_flag_control <= next_ctrl;
      low_count_zero             <= next_low0;
      high_count_zero            <= next_high0;
      low_count_one              <= next_low1;
      high_count_one             <= next_high1;
      t1_ovf_pulse_o             <= next_t1_pulse;
      pin0_prev                  <= count_pin_zero_i;
      pin1_prev                  <= count_pin_one_i;
      gin0_prev                  <= gin0_act;
      gin1_prev                  <= gin1_act;
      if (sfr_wr_i && sfr_addr_i == `ADDR_MODE)
        timer_mode_select <= sfr_wdata_i;
      if (sfr_wr_i && sfr_addr_i == `ADDR_CLKSEL)
        timer_clock_select_reg <= sfr_wdata_i;
    end
  end

  always @* begin
    case (sfr_addr_i)
      `ADDR_CTRL:      sfr_rdata_o = timer_run_and_flag_control;
      `ADDR_MODE:      sfr_rdata_o = timer_mode_select;
      `ADDR_LOW_ZERO:  sfr_rdata_o = low_count_zero;
      `ADDR_LOW_ONE:   sfr_rdata_o = low_count_one;
      `ADDR_HIGH_ZERO: sfr_rdata_o = high_count_zero;
      `ADDR_HIGH_ONE:  sfr_rdata_o = high_count_one;
      `ADDR_CLKSEL:    sfr_rdata_o = timer_clock_select_reg;
      default:         sfr_rdata_o = 8'h00;
    endcase
  end

  assign ovf_flag_zero_o     = ovf_flag_zero;
  assign ovf_flag_one_o      = ovf_flag_one;
  assign ext_irq_flag_zero_o = timer_run_and_flag_control[`BIT_EXT_ZERO];
  assign ext_irq_flag_one_o  = timer_run_and_flag_control[`BIT_EXT_ONE];
endmodule // dual_timer

// [design/timer_pair_defs.vh]
/*
  Constants for the dual counter/timer block: register addresses, field
  positions, reset values and prescale divide ratios.
  Assumes inclusion by bare name from the timer design files.
*/
`ifndef TIMER_PAIR_DEFS_VH
`define TIMER_PAIR_DEFS_VH
`define ADDR_CTRL      8'h88
`define ADDR_MODE      8'h89
`define ADDR_LOW_ZERO  8'h8A
`define ADDR_LOW_ONE   8'h8B
`define ADDR_HIGH_ZERO 8'h8C
`define ADDR_HIGH_ONE  8'h8D
`define ADDR_CLKSEL    8'h8E
`define RESET_BYTE     8'h00
`define BIT_OVF_ONE    3'h7
`define BIT_RUN_ONE    3'h6
`define BIT_OVF_ZERO   3'h5
`define BIT_RUN_ZERO   3'h4
`define BIT_EXT_ONE    3'h3
`define BIT_TYPE_ONE   3'h2
`define BIT_EXT_ZERO   3'h1
`define BIT_TYPE_ZERO  3'h0
`define MODE_13        2'h0
`define MODE_16        2'h1
`define MODE_RELOAD    2'h2
`define MODE_SPLIT     2'h3
`define DIV_A          6'h0C
`define DIV_B          6'h04
`define DIV_C          6'h30
`define DIV_EXT        6'h08
`endif

// [design/prescale_gen.v]
/*
  Prescaled tick generator for both timers.
  Assumes the external clock input is already synchronous to core_clk_i.
*/
`timescale 1ns/100ps
`include "timer_pair_defs.vh"
module prescale_gen (
  input  wire       core_clk_i,      // system clock
  input  wire       rst_i,           // async reset, active high
  input  wire [1:0] prescale_sel_i,  // divide ratio select
  input  wire       ext_clk_i,       // external clock, synchronous
  output reg        tick_o           // one-cycle prescaled tick
);
  reg  [5:0] div_cnt;
  reg        ext_prev;
  wire       ext_rise = ext_clk_i & ~ext_prev;
  wire       use_ext  = (prescale_sel_i == 2'h3);
  wire [5:0] limit    = (prescale_sel_i == 2'h0) ? `DIV_A :
                        (prescale_sel_i == 2'h1) ? `DIV_B :
                        (prescale_sel_i == 2'h2) ? `DIV_C : `DIV_EXT;
  wire       step     = use_ext ? ext_rise : 1'b1;

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt  <= 6'h00;
      ext_prev <= 1'b0;
      tick_o   <= 1'b0;
    end else begin
      ext_prev <= ext_clk_i;
      tick_o   <= 1'b0;
      if (step) begin
        // counter re-ranges itself if the ratio is changed mid-count
        if (div_cnt >= limit - 6'h01) begin
          div_cnt <= 6'h00;
          tick_o  <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 6'h01;
        end
      end
    end
  end
endmodule // prescale_gen

// [verification/timer_pair_sva.sv]
/*
  Port-level checker for the dual counter/timer block.
  Assumes binding onto dual_timer; sees only its ports.
*/
`timescale 1ns/100ps
module timer_pair_sva (
  input wire logic       core_clk_i,          // system clock
  input wire logic       rst_i,               // async reset
  input wire logic [7:0] sfr_addr_i,          // register address
  input wire logic       sfr_wr_i,            // byte write strobe
  input wire logic [7:0] sfr_wdata_i,         // byte write data
  input wire logic       sfr_bit_wr_i,        // bit write strobe
  input wire logic [2:0] sfr_bit_sel_i,       // bit index
  input wire logic       sfr_bit_val_i,       // bit value
  input wire logic [7:0] sfr_rdata_o,         // read data
  input wire logic       sfr_hit_o,           // address hit
  input wire logic       gating_input_zero_i, // input 0
  input wire logic       gating_input_one_i,  // input 1
  input wire logic       gating_polarity_zero_i, // polarity 0
  input wire logic       gating_polarity_one_i,  // polarity 1
  input wire logic       ovf_flag_zero_o,     // overflow flag 0
  input wire logic       ovf_flag_one_o,      // overflow flag 1
  input wire logic       ext_irq_flag_zero_o, // ext flag 0
  input wire logic       ext_irq_flag_one_o,  // ext flag 1
  input wire logic       t1_ovf_pulse_o       // timer 1 overflow pulse
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  hit_decode_a: assert property (
    sfr_hit_o == (sfr_addr_i >= 8'h88 && sfr_addr_i <= 8'h8E))
    else $error("address decode wrong");
  unmapped_zero_a: assert property (
    !sfr_hit_o |-> sfr_rdata_o == 8'h00) else $error("unmapped read not 0");
  ctrl_mirror_a: assert property (sfr_addr_i == 8'h88 |->
    sfr_rdata_o[5] == ovf_flag_zero_o && sfr_rdata_o[7] == ovf_flag_one_o &&
    sfr_rdata_o[1] == ext_irq_flag_zero_o &&
    sfr_rdata_o[3] == ext_irq_flag_one_o) else $error("flag pins differ");
  // count bytes included: a write must beat a same-cycle step
  byte_readback_a: assert property (
    (sfr_wr_i && !sfr_bit_wr_i && sfr_addr_i >= 8'h89 && sfr_addr_i <= 8'h8E)
    ##1 (sfr_addr_i == $past(sfr_addr_i)) |-> sfr_rdata_o == $past(sfr_wdata_i))
    else $error("byte write not read back");
  bit_readback_a: assert property (
    (sfr_bit_wr_i && !sfr_wr_i && sfr_addr_i == 8'h88 && !sfr_bit_sel_i[0])
    ##1 (sfr_addr_i == 8'h88)
    |-> sfr_rdata_o[$past(sfr_bit_sel_i)] == $past(sfr_bit_val_i))
    else $error("bit write not read back");
  ext_cause_zero_a: assert property (
    $rose(ext_irq_flag_zero_o) && !$past(sfr_wr_i) && !$past(sfr_bit_wr_i)
    |-> $past(gating_input_zero_i) == $past(gating_polarity_zero_i))
    else $error("ext flag 0 set while input inactive");
  ext_cause_one_a: assert property (
    $rose(ext_irq_flag_one_o) && !$past(sfr_wr_i) && !$past(sfr_bit_wr_i)
    |-> $past(gating_input_one_i) == $past(gating_polarity_one_i))
    else $error("ext flag 1 set while input inactive");
  reset_clear_a: assert property (disable iff (1'b0) rst_i |->
    !ovf_flag_zero_o && !ovf_flag_one_o && !ext_irq_flag_zero_o &&
    !ext_irq_flag_one_o && !t1_ovf_pulse_o) else $error("flags up in reset");

  pulse_seen_c: cover property (t1_ovf_pulse_o);
  ovf_zero_c: cover property ($rose(ovf_flag_zero_o));
  ext_zero_c: cover property ($rose(ext_irq_flag_zero_o));
endmodule // timer_pair_sva

// [verification/cpu_core_model.sv]
/*
  CPU side of the register bus: byte writes, single-bit writes, reads.
  Assumes each task is entered just after a rising clock edge.
*/
`timescale 1ns/100ps
module cpu_core_model (
  input  wire       core_clk_i, // system clock
  output reg  [7:0] addr_o,     // register address
  output reg        wr_o,       // byte write strobe
  output reg  [7:0] wdata_o,    // byte write data
  output reg        bit_wr_o,   // single-bit write strobe
  output reg  [2:0] bit_sel_o,  // bit index
  output reg        bit_val_o   // bit value
);
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    bit_wr_o = 1'b0;
    bit_sel_o = 3'h0;
    bit_val_o = 1'b0;
  end
  // address is left in place so the written register stays visible
  task wr(input [7:0] a, input [7:0] d);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge core_clk_i);
    #1 wr_o = 1'b0;
    // one idle edge keeps the strobe low between back-to-back calls
    @(posedge core_clk_i);
    #1;
  endtask
  task bwr(input [2:0] s, input v);
    addr_o = 8'h88;
    bit_sel_o = s;
    bit_val_o = v;
    bit_wr_o = 1'b1;
    @(posedge core_clk_i);
    #1 bit_wr_o = 1'b0;
    @(posedge core_clk_i);
    #1;
  endtask
  task look(input [7:0] a);
    addr_o = a;
  endtask
endmodule // cpu_core_model

// [verification/dual_counter_timer_modes_tb_top.sv]
/*
  Self-checking bench for dual_timer with an integer reference model.
  Assumes the CPU model and checker files are compiled first.
*/
`timescale 1ns/100ps
module dual_counter_timer_modes_tb_top;
  reg        core_clk_i = 1'b0;
  reg        rst_i = 1'b0;
  reg        xclk = 1'b0;
  wire [7:0] addr, wdata, rdata;
  wire [2:0] bsel;
  wire       wr, bwr, bval, hit, ovf0, ovf1, ext0, ext1, pulse;
  reg  [1:0] pin = 2'b11;
  reg  [1:0] gin = 2'b00;
  // active high with inputs low: level flags stay clear after reset
  reg  [1:0] pol = 2'b11;
  reg  [3:0] vec = 4'h0;
  integer    err_count = 0;
  integer    checks = 0;
  integer    seed = 65798;
  integer    k, t, m, hi, lo, ovf, n, cs, g, en, cnt;

  always #50 core_clk_i = ~core_clk_i;

  cpu_core_model i_cpu_core_model (.core_clk_i(core_clk_i), .addr_o(addr),
    .wr_o(wr), .wdata_o(wdata), .bit_wr_o(bwr), .bit_sel_o(bsel),
    .bit_val_o(bval));
  dual_timer i_dual_timer (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata),
    .sfr_bit_wr_i(bwr), .sfr_bit_sel_i(bsel), .sfr_bit_val_i(bval),
    .sfr_rdata_o(rdata), .sfr_hit_o(hit), .count_pin_zero_i(pin[0]),
    .count_pin_one_i(pin[1]), .gating_input_zero_i(gin[0]),
    .gating_input_one_i(gin[1]), .gating_polarity_zero_i(pol[0]),
    .gating_polarity_one_i(pol[1]), .ext_clk_i(xclk),
    .vector_t0_i(vec[0]), .vector_t1_i(vec[1]), .vector_x0_i(vec[2]),
    .vector_x1_i(vec[3]), .ovf_flag_zero_o(ovf0), .ovf_flag_one_o(ovf1),
    .ext_irq_flag_zero_o(ext0), .ext_irq_flag_one_o(ext1),
    .t1_ovf_pulse_o(pulse));

  task chk(input [7:0] seen, input [7:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task idle(input integer c);
    repeat (c) @(posedge core_clk_i);
    #1;
  endtask
  task rdchk(input [7:0] a, input [7:0] exp);
    i_cpu_core_model.look(a);
    idle(1);
    chk(rdata, exp);
  endtask
  task stop_test;
    $display("errors %0d, checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // reference count: c steps of mode md on integer bytes
  task automatic adv(input integer md, c, inout integer h, l, f);
    integer v;
    repeat (c) begin
      if (md == 0) begin
        v = h * 32 + (l & 31) + 1;
        f = f | (v >> 13);
        h = (v >> 5) & 255;
        l = (l & 224) | (v & 31);
      end else if (md == 1) begin
        v = h * 256 + l + 1;
        f = f | (v >> 16);
        h = (v >> 8) & 255;
        l = v & 255;
      end else begin
        l = l + 1;
        if (l > 255) begin
          l = h;
          f = 1;
        end
      end
    end
  endtask

  initial begin
    #3000000;
    err_count = err_count + 1;
    stop_test;
  end

  initial begin
    // asserted off the clock edge so the async reset sees a rising edge
    #1 rst_i = 1'b1;
    idle(4);
    rst_i = 1'b0;
    idle(1);
    for (k = 8'h88; k <= 8'h8F; k = k + 1)
      rdchk(k[7:0], 8'h00);
    for (k = 0; k < 12; k = k + 1) begin
      t = k % 2;
      m = (k / 2) % 3;
      hi = $random(seed) & 255;
      lo = $random(seed) & 255;
      g = $random(seed) & 1;
      cs = $random(seed) & 3;
      pol[t] = $random(seed);
      gin[t] = $random(seed);
      en = !g || gin[t] == pol[t];
      n = (cs == 3) ? 2 + ($random(seed) & 63) : 96;
      i_cpu_core_model.wr(8'h8A + t, lo); // preload before run
      i_cpu_core_model.wr(8'h8C + t, hi);
      i_cpu_core_model.wr(8'h89, (g * 8 + m) << (4 * t));
      i_cpu_core_model.wr(8'h8E, (cs == 3) ? 8'h04 << t : cs);
      i_cpu_core_model.wr(8'h88, 8'h00);
      i_cpu_core_model.bwr(4 + 2 * t, 1'b1);
      idle(n - 2); // the bit write itself spends two cycles
      i_cpu_core_model.bwr(4 + 2 * t, 1'b0);
      ovf = 0;
      n = (cs == 3) ? n : n / (cs == 0 ? 12 : cs == 1 ? 4 : 48);
      adv(m, en ? n : 0, hi, lo, ovf);
      rdchk(8'h8A + t, lo);
      rdchk(8'h8C + t, hi);
      chk(t ? ovf1 : ovf0, ovf);
    end
    for (t = 0; t < 2; t = t + 1) begin
      i_cpu_core_model.wr(8'h8A + t, 8'h00);
      i_cpu_core_model.wr(8'h89, 8'h05 << (4 * t));
      i_cpu_core_model.bwr(4 + 2 * t, 1'b1);
      repeat (5) begin // each pin level held two cycles
        pin[t] = 1'b0;
        idle(2);
        pin[t] = 1'b1;
        idle(2);
      end
      i_cpu_core_model.bwr(4 + 2 * t, 1'b0);
      rdchk(8'h8A + t, 8'h05);
    end
    i_cpu_core_model.wr(8'h8A, 8'hFE);
    i_cpu_core_model.wr(8'h8C, 8'hFF);
    i_cpu_core_model.wr(8'h8B, 8'hFF);
    i_cpu_core_model.wr(8'h8D, 8'hFF);
    i_cpu_core_model.wr(8'h8E, 8'h0C);
    i_cpu_core_model.wr(8'h88, 8'h00);
    i_cpu_core_model.wr(8'h89, 8'h33);
    i_cpu_core_model.bwr(4, 1'b1);
    i_cpu_core_model.bwr(6, 1'b1);
    idle(1);
    i_cpu_core_model.bwr(4, 1'b0);
    i_cpu_core_model.bwr(6, 1'b0);
    rdchk(8'h8A, 8'h03);
    rdchk(8'h8C, 8'h04);
    rdchk(8'h8B, 8'hFF);
    chk({6'h0, ovf1, ovf0}, 8'h03);
    vec[1:0] = 2'b11;
    idle(1);
    vec = 4'h0;
    chk({6'h0, ovf1, ovf0}, 8'h00);
    i_cpu_core_model.wr(8'h89, 8'h23);
    idle(2);
    cnt = 0;
    repeat (8) begin
      cnt = cnt + pulse;
      idle(1);
    end
    chk(cnt, 8);
    chk(ovf1, 0);
    i_cpu_core_model.wr(8'h8B, 8'h10);
    rdchk(8'h8B, 8'h12);
    i_cpu_core_model.wr(8'h89, 8'h33);
    pol = 2'b01;
    gin = 2'b10;
    i_cpu_core_model.wr(8'h88, 8'h01);
    chk({6'h0, ext1, ext0}, 8'h00);
    gin = 2'b01;
    idle(2);
    chk({6'h0, ext1, ext0}, 8'h03);
    vec[3:2] = 2'b11;
    gin = 2'b11;
    idle(1);
    vec = 4'h0;
    idle(1);
    chk({6'h0, ext1, ext0}, 8'h00);
    i_cpu_core_model.wr(8'h89, 8'h30);
    i_cpu_core_model.wr(8'h8B, 8'h40);
    i_cpu_core_model.bwr(6, 1'b1);
    idle(4);
    i_cpu_core_model.bwr(6, 1'b0);
    rdchk(8'h8B, 8'h40);
    i_cpu_core_model.wr(8'h8A, 8'h00);
    i_cpu_core_model.wr(8'h8C, 8'h00);
    i_cpu_core_model.wr(8'h8E, 8'h03);
    i_cpu_core_model.wr(8'h89, 8'h01);
    i_cpu_core_model.bwr(4, 1'b1);
    // 32 external rising edges give four prescaled ticks
    repeat (32) begin
      xclk = 1'b1;
      idle(2);
      xclk = 1'b0;
      idle(2);
    end
    i_cpu_core_model.bwr(4, 1'b0);
    rdchk(8'h8A, 8'h04);
    stop_test;
  end
endmodule // dual_counter_timer_modes_tb_top

bind dual_timer timer_pair_sva i_timer_pair_sva (.core_clk_i, .rst_i,
  .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_bit_wr_i, .sfr_bit_sel_i,
  .sfr_bit_val_i, .sfr_rdata_o, .sfr_hit_o, .gating_input_zero_i,
  .gating_input_one_i, .gating_polarity_zero_i, .gating_polarity_one_i,
  .ovf_flag_zero_o, .ovf_flag_one_o, .ext_irq_flag_zero_o,
  .ext_irq_flag_one_o, .t1_ovf_pulse_o);
